// File: logic/sepc_top.sv
// Purpose : I2C slave byte engine with strap configuration and power modes.
// Assumes : Bus pins are already synchronous to clk; SCL is sampled at 50 MHz.
// Notes   : Frame contents beyond length and binding checks are handled upstream.
`timescale 1ns/1ps
module sepc_top #(
   parameter int unsigned STRAP_CYCLES = sepc_pkg::STRAP_CYC,
   parameter int unsigned SLEEP_CYCLES = sepc_pkg::SLEEP_CYC,
   parameter int unsigned DEEP_CYCLES  = sepc_pkg::DEEP_CYC,
   parameter int unsigned FWT_CYCLES   = sepc_pkg::FWT_CYC
) (
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       interface_enable_strap,
   input  wire logic       address_select_strap,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            scl_oe,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   output logic            frame_error,
   output logic            fwt_expired,
   output logic            asleep,
   output logic            deep_sleep,
   output logic            configured
);
   import sepc_pkg::*;

   // Counts below these floors would make a timer fire at once or every reset enter deep sleep.
   if (STRAP_CYCLES < 1 || SLEEP_CYCLES < 1 ||
       DEEP_CYCLES < 2 || FWT_CYCLES < 1) begin : g_bad_cnt
      $error("sepc_top: timing counts too small");
   end

   function automatic logic bit_done(input logic [3:0] c);
      bit_done = (c == 4'h7);
   endfunction

   // ----------------------------------------------------------------
   // Edge detection and bus condition decode
   // ----------------------------------------------------------------
   logic scl_d_ff, sda_d_ff;
   logic scl_rise, scl_fall, start_c, stop_c, sda_fall;
   always_ff @(posedge clk) begin
      scl_d_ff <= scl_in;
      sda_d_ff <= sda_in;
   end
   assign scl_rise = scl_in & ~scl_d_ff;
   assign scl_fall = ~scl_in & scl_d_ff;
   assign sda_fall = ~sda_in & sda_d_ff;
   assign start_c  = scl_in & sda_fall;
   assign stop_c   = scl_in & sda_in & ~sda_d_ff;

   // ----------------------------------------------------------------
   // Power manager: boot strap sampling, sleep, deep sleep
   // ----------------------------------------------------------------
   sepc_pm_t    pm_ff, nxt_pm;
   logic [31:0] tmr_ff, nxt_tmr;
   logic [31:0] rlow_ff, nxt_rlow;
   logic        en_ff, nxt_en, asel_ff, nxt_asel;
   logic        bus_act;
   logic        held_scl_oe_ff, nxt_held_scl_oe, held_sda_oe_ff, nxt_held_sda_oe;
   logic        eng_scl_oe, eng_sda_oe;
   assign bus_act = (scl_in != scl_d_ff) || (sda_in != sda_d_ff);

   always_comb begin
      nxt_pm          = pm_ff;
      nxt_tmr         = tmr_ff;
      nxt_en          = en_ff;
      nxt_asel        = asel_ff;
      nxt_held_scl_oe = held_scl_oe_ff;
      nxt_held_sda_oe = held_sda_oe_ff;
      nxt_rlow = reset_n ? 32'h0000_0000 : ((rlow_ff == DEEP_CYCLES[31:0]) ? rlow_ff
                                                                          : rlow_ff + 32'd1);
      case (pm_ff)
         SEPC_BOOT: begin
            nxt_tmr = tmr_ff + 32'd1;
            if (tmr_ff + 32'd1 >= STRAP_CYCLES[31:0]) begin
               nxt_en   = interface_enable_strap & scl_in & sda_in;
               nxt_asel = address_select_strap;
               nxt_pm   = SEPC_RUN;
               nxt_tmr  = 32'h0000_0000;
            end
         end
         SEPC_RUN: begin
            nxt_tmr = bus_act ? 32'h0000_0000 : tmr_ff + 32'd1;
            if (!bus_act && tmr_ff + 32'd1 >= SLEEP_CYCLES[31:0]) begin
               nxt_pm          = SEPC_SLEEP;
               nxt_held_scl_oe = eng_scl_oe;
               nxt_held_sda_oe = eng_sda_oe;
               nxt_tmr         = 32'h0000_0000;
            end
         end
         SEPC_SLEEP: begin
            if (sda_fall) begin
               nxt_pm = SEPC_RUN;
            end
         end
         SEPC_DEEP: begin
            if (reset_n) begin
               nxt_pm  = SEPC_BOOT;
               nxt_tmr = 32'h0000_0000;
            end
         end
         default: nxt_pm = SEPC_BOOT;
      endcase
   end

   always_ff @(posedge clk) begin
      rlow_ff <= nxt_rlow;
      if (!reset_n) begin
         if (rlow_ff + 32'd1 >= DEEP_CYCLES[31:0]) begin
            pm_ff <= SEPC_DEEP;
         end else begin
            pm_ff <= SEPC_BOOT;
         end
         tmr_ff         <= 32'h0000_0000;
         en_ff          <= 1'b0;
         asel_ff        <= 1'b0;
         held_scl_oe_ff <= 1'b0;
         held_sda_oe_ff <= 1'b0;
      end else begin
         pm_ff          <= nxt_pm;
         tmr_ff         <= nxt_tmr;
         en_ff          <= nxt_en;
         asel_ff        <= nxt_asel;
         held_scl_oe_ff <= nxt_held_scl_oe;
         held_sda_oe_ff <= nxt_held_sda_oe;
      end
   end

   logic       run;
   logic [6:0] my_addr;
   assign run        = (pm_ff == SEPC_RUN);
   assign my_addr    = asel_ff ? ADDR_ALT : ADDR_BASE;
   assign asleep     = (pm_ff == SEPC_SLEEP);
   assign deep_sleep = (pm_ff == SEPC_DEEP);
   assign configured = en_ff & (pm_ff != SEPC_BOOT) & (pm_ff != SEPC_DEEP);

   // ----------------------------------------------------------------
   // I2C slave byte engine
   // ----------------------------------------------------------------
   sepc_st_t   st_ff, nxt_st;
   logic [7:0] sh_ff, nxt_sh, rxd_ff, nxt_rxd;
   logic [3:0] bc_ff, nxt_bc;
   logic [8:0] len_ff, nxt_len;
   logic       rd_ff, nxt_rd, rxv_ff, nxt_rxv, ferr_ff, nxt_ferr, acko_ff, nxt_acko;
   logic       drv_ff, nxt_drv, first_ff, nxt_first;
   logic [31:0] fwt_ff, nxt_fwt;
   logic        fwe_ff, nxt_fwe;

   always_comb begin
      nxt_st = st_ff; nxt_sh = sh_ff; nxt_bc = bc_ff; nxt_len = len_ff; nxt_rd = rd_ff;
      nxt_rxd = rxd_ff; nxt_rxv = 1'b0; nxt_ferr = ferr_ff; nxt_acko = acko_ff;
      nxt_drv = drv_ff; nxt_first = first_ff; nxt_fwe = fwe_ff;
      nxt_fwt = (st_ff == SEPC_IDLE) ? 32'h0000_0000 : fwt_ff + 32'd1;
      if (fwt_ff + 32'd1 >= FWT_CYCLES[31:0] && st_ff != SEPC_IDLE) begin
         nxt_fwe = 1'b1;
      end
      if (!run || !en_ff || stop_c) begin
         nxt_st  = SEPC_IDLE;
         nxt_drv = 1'b0;
      end else if (start_c) begin
         nxt_st = SEPC_ADDR; nxt_bc = 4'h0; nxt_drv = 1'b0; nxt_len = 9'h000;
         nxt_first = 1'b1; nxt_fwe = 1'b0;
      end else begin
         case (st_ff)
            SEPC_IDLE: nxt_drv = 1'b0;
            SEPC_ADDR, SEPC_RXB: begin
               if (scl_rise) begin
                  nxt_sh = {sh_ff[6:0], sda_in};
                  nxt_bc = bc_ff + 4'h1;
               end
               if (scl_fall && bc_ff == 4'h8) begin
                  nxt_bc = 4'h0;
                  if (st_ff == SEPC_ADDR) begin
                     if (sh_ff[7:1] == my_addr) begin
                        nxt_rd = sh_ff[0]; nxt_drv = 1'b1; nxt_st = SEPC_AACK;
                     end else begin
                        nxt_st = SEPC_IDLE;
                     end
                  end else begin
                     nxt_len = len_ff + 9'h001;
                     if (len_ff >= {1'b0, H2D_MAX_BLOCK} ||
                         (first_ff && sh_ff[3:0] == PCB_BIND_SEL)) begin
                        nxt_ferr = 1'b1; nxt_drv = 1'b0;
                     end else begin
                        nxt_rxd = sh_ff; nxt_rxv = 1'b1; nxt_drv = 1'b1;
                     end
                     nxt_first = 1'b0;
                     nxt_st = SEPC_RACK;
                  end
               end
            end
            SEPC_AACK, SEPC_RACK: begin
               if (scl_fall) begin
                  nxt_drv = 1'b0; nxt_bc = 4'h0;
                  if (rd_ff && st_ff == SEPC_AACK) begin
                     // Outbound limit, 0xFF fill when empty.
                     nxt_sh  = (tx_valid && len_ff < {1'b0, D2H_MAX_BLOCK}) ? tx_data : 8'hFF;
                     nxt_len = len_ff + 9'h001;
                     nxt_drv = ~nxt_sh[7]; nxt_st = SEPC_TXB;
                  end else begin
                     nxt_st = SEPC_RXB;
                  end
               end
            end
            SEPC_TXB: begin
               if (scl_fall) begin
                  if (bit_done(bc_ff)) begin
                     nxt_drv = 1'b0; nxt_st = SEPC_TACK;
                  end else begin
                     nxt_sh = {sh_ff[6:0], 1'b1}; nxt_drv = ~sh_ff[6];
                     nxt_bc = bc_ff + 4'h1;
                  end
               end
            end
            SEPC_TACK: begin
               if (scl_rise) nxt_acko = ~sda_in;
               if (scl_fall) begin
                  nxt_bc = 4'h0;
                  if (acko_ff) begin
                     nxt_sh  = (tx_valid && len_ff < {1'b0, D2H_MAX_BLOCK}) ? tx_data : 8'hFF;
                     nxt_len = len_ff + 9'h001;
                     nxt_drv = ~nxt_sh[7]; nxt_st = SEPC_TXB;
                  end else begin
                     nxt_st = SEPC_IDLE;
                  end
               end
            end
            default: nxt_st = SEPC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_ff <= SEPC_IDLE; sh_ff <= 8'h00; bc_ff <= 4'h0; len_ff <= 9'h000;
         rd_ff <= 1'b0; rxd_ff <= 8'h00; rxv_ff <= 1'b0; ferr_ff <= 1'b0;
         acko_ff <= 1'b0; drv_ff <= 1'b0; first_ff <= 1'b0;
         fwt_ff <= 32'h0000_0000; fwe_ff <= 1'b0;
      end else if (pm_ff != SEPC_SLEEP) begin
         st_ff <= nxt_st; sh_ff <= nxt_sh; bc_ff <= nxt_bc; len_ff <= nxt_len;
         rd_ff <= nxt_rd; rxd_ff <= nxt_rxd; rxv_ff <= nxt_rxv; ferr_ff <= nxt_ferr;
         acko_ff <= nxt_acko; drv_ff <= nxt_drv; first_ff <= nxt_first;
         fwt_ff <= nxt_fwt; fwe_ff <= nxt_fwe;
      end
   end

   assign eng_sda_oe = drv_ff;
   assign eng_scl_oe = 1'b0;
   assign tx_ready   = run & (st_ff == SEPC_TACK || st_ff == SEPC_AACK) & scl_fall
                       & (rd_ff) & (st_ff == SEPC_TACK ? acko_ff : 1'b1)
                       & (len_ff < {1'b0, D2H_MAX_BLOCK});
   assign rx_data     = rxd_ff;
   assign rx_valid    = rxv_ff;
   assign frame_error = ferr_ff;
   assign fwt_expired = fwe_ff;
   assign scl_out     = 1'b0;
   assign sda_out     = 1'b0;
   // Hold pins in sleep; release in deep sleep.
   assign sda_oe = deep_sleep ? 1'b0 : (asleep ? held_sda_oe_ff : eng_sda_oe);
   assign scl_oe = deep_sleep ? 1'b0 : (asleep ? held_scl_oe_ff : eng_scl_oe);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_deep_pads;
      @(posedge clk) deep_sleep |-> (!sda_oe && !scl_oe);
   endproperty
   a_deep_pads: assert property (p_deep_pads) else $error("pad driven in deep sleep");

   property p_sleep_hold;
      @(posedge clk) disable iff (!reset_n) (asleep && $past(asleep)) |-> $stable(sda_oe);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("pin changed in sleep");

   property p_wake;
      @(posedge clk) disable iff (!reset_n) (asleep && sda_fall) |=> !asleep;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on sda fall");

   property p_exit_deep;
      @(posedge clk) (deep_sleep && reset_n) |=> !deep_sleep;
   endproperty
   a_exit_deep: assert property (p_exit_deep) else $error("deep sleep not left");

   property p_no_addr;
      @(posedge clk) disable iff (!reset_n) !en_ff |-> !sda_oe || asleep;
   endproperty
   a_no_addr: assert property (p_no_addr) else $error("answered while disabled");

   property p_frozen;
      @(posedge clk) disable iff (!reset_n) (asleep && $past(asleep)) |-> $stable(st_ff);
   endproperty
   a_frozen: assert property (p_frozen) else $error("engine moved in sleep");

   property p_rx_len;
      @(posedge clk) disable iff (!reset_n) rx_valid |-> len_ff <= {1'b0, H2D_MAX_BLOCK};
   endproperty
   a_rx_len: assert property (p_rx_len) else $error("block too long accepted");

   property p_retain;
      @(posedge clk) disable iff (!reset_n) (asleep ##1 !asleep) |-> $stable(en_ff);
   endproperty
   a_retain: assert property (p_retain) else $error("config lost on wake");
endmodule

// File: logic/sepc_pkg.sv
// Purpose : Constants for the secure element I2C slave with power-mode control.
// Assumes : 50 MHz clock, synchronous active-low reset.
// Notes   : Timing counts are derived from times in their own units.
package sepc_pkg;
   localparam int unsigned CLK_HZ         = 50_000_000;
   localparam int unsigned STRAP_HOLD_US  = 500;
   localparam int unsigned SLEEP_IDLE_MS  = 312;
   localparam int unsigned DEEP_RST_US    = 500;
   localparam int unsigned FWT_MS         = 320;
   localparam int unsigned STRAP_CYC      = (CLK_HZ / 1_000_000) * STRAP_HOLD_US;
   localparam int unsigned SLEEP_CYC      = (CLK_HZ / 1_000) * SLEEP_IDLE_MS;
   localparam int unsigned DEEP_CYC       = (CLK_HZ / 1_000_000) * DEEP_RST_US + 1;
   localparam int unsigned FWT_CYC        = (CLK_HZ / 1_000) * FWT_MS;
   localparam logic [6:0]  ADDR_BASE      = 7'h48;
   localparam logic [6:0]  ADDR_ALT       = 7'h49;
   localparam logic [7:0]  H2D_MAX_BLOCK  = 8'hFF;
   localparam logic [7:0]  D2H_MAX_BLOCK  = 8'hFC;
   localparam logic [3:0]  PCB_BIND_SEL   = 4'hF;
   typedef enum logic [2:0] {
      SEPC_IDLE = 3'b000,
      SEPC_ADDR = 3'b001,
      SEPC_AACK = 3'b010,
      SEPC_RXB  = 3'b011,
      SEPC_RACK = 3'b100,
      SEPC_TXB  = 3'b101,
      SEPC_TACK = 3'b110
   } sepc_st_t;
   typedef enum logic [1:0] {
      SEPC_BOOT  = 2'b00,
      SEPC_RUN   = 2'b01,
      SEPC_SLEEP = 2'b10,
      SEPC_DEEP  = 2'b11
   } sepc_pm_t;
endpackage

// File: sim/sepc_host_model.sv
// Purpose : I2C bus master model facing the secure element slave.
// Assumes : Open-drain lines with pull-ups; lines change just after rising edges.
// Notes   : A quarter bit of 32 clocks keeps the bus just under 400 kbit/s.
`timescale 1ns/1ps
module sepc_host_model #(
   parameter int unsigned QTR = 32
) (
   input  wire logic clk,
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output logic      scl_line,
   output logic      sda_line
);
   logic scl_low;
   logic sda_low;

   // --------------------------------------------------------------
   // Wired lines
   // --------------------------------------------------------------
   // A released line floats to the pull-up level, never to a stale value.
   assign scl_line = ~(scl_low | scl_oe);
   assign sda_line = ~(sda_low | sda_oe);

   // Both lines start released.
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end

   // --------------------------------------------------------------
   // Bus primitives
   // --------------------------------------------------------------
   // Pulls or releases both lines together just after a clock edge.
   task automatic drive_lines(input logic c, input logic d);
      @(posedge clk);
      scl_low <= c;
      sda_low <= d;
   endtask

   // Bit pacing.
   // Four quarters per bit stay at or below the fast-mode rate.
   task automatic qwait(input int n);
      repeat (n * QTR) @(posedge clk);
   endtask

   // Byte framing.
   // A start pulls SDA while SCL is high, then takes SCL low.
   task automatic start;
      drive_lines(1'b0, 1'b1);
      qwait(1);
      drive_lines(1'b1, 1'b1);
      qwait(1);
   endtask

   // Data is set with SCL low and sampled in the middle of SCL high.
   task automatic bit_io(input logic b, output logic got);
      drive_lines(1'b1, ~b);
      qwait(1);
      drive_lines(1'b0, ~b);
      qwait(1);
      got = sda_line;
      qwait(1);
      drive_lines(1'b1, ~b);
      qwait(1);
   endtask

   // Sends eight bits MSB first, then drives or reads the ninth bit.
   task automatic byte_io(input logic [7:0] tx, input logic ack_bit,
                          output logic [7:0] rx, output logic nine);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_bit, nine);
   endtask

   // A stop releases SCL first and SDA afterwards.
   task automatic stop;
      drive_lines(1'b1, 1'b1);
      qwait(1);
      drive_lines(1'b0, 1'b1);
      qwait(1);
      drive_lines(1'b0, 1'b0);
      qwait(1);
   endtask

   // Wake edge.
   // A single SDA fall and rise while SCL stays high.
   task automatic wake;
      drive_lines(1'b0, 1'b1);
      qwait(1);
      drive_lines(1'b0, 1'b0);
      qwait(1);
   endtask
endmodule

// File: sim/sepc_top_tb.sv
// Purpose : Self-checking bench for the secure element I2C slave.
// Assumes : Shortened counts for boot, sleep, deep sleep and frame wait.
// Notes   : Received bytes are checked against a queue of expected bytes.
`timescale 1ns/1ps
module sepc_top_tb;
   import sepc_pkg::*;
   localparam int unsigned SLEEP_N = 200;
   logic        clk;
   logic        reset_n;
   logic        interface_enable_strap;
   logic        address_select_strap;
   logic        scl_in;
   logic        sda_in;
   logic        scl_oe;
   logic        sda_oe;
   logic        scl_out;
   logic        sda_out;
   logic [7:0]  tx_data;
   logic        tx_valid;
   logic        tx_ready;
   logic [7:0]  rx_data;
   logic        rx_valid;
   logic        frame_error;
   logic        fwt_expired;
   logic        asleep;
   logic        deep_sleep;
   logic        configured;
   logic [15:0] rnd;
   logic [7:0]  exp_q[$];
   int          fail_count;
   int          samples_checked;
   int          ready_count = 0;

   sepc_top #(.STRAP_CYCLES(20), .SLEEP_CYCLES(SLEEP_N), .DEEP_CYCLES(10),
              .FWT_CYCLES(500)) sepc_top_i (
      .clk(clk), .reset_n(reset_n), .interface_enable_strap(interface_enable_strap),
      .address_select_strap(address_select_strap), .scl_in(scl_in), .sda_in(sda_in),
      .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid),
      .frame_error(frame_error), .fwt_expired(fwt_expired), .asleep(asleep),
      .deep_sleep(deep_sleep), .configured(configured));

   sepc_host_model #(.QTR(32)) sepc_host_model_i (
      .clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_in), .sda_line(sda_in));

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Waits a bounded time for configured (0), asleep (1) or deep_sleep (2).
   task automatic wait_sig(input int which, input logic val, input int lim);
      logic s;
      for (int i = 0; i <= lim; i++) begin
         @(posedge clk);
         s = (which == 0) ? configured : (which == 1) ? asleep : deep_sleep;
         if (s === val) return;
      end
      fail_count++;
      $display("BAD wait %0d expected %b seen %b", which, val, s);
      end_sim;
   endtask

   // Resets with given straps; a long hold asks for deep sleep.
   task automatic boot(input logic en, input logic sel, input logic low, input int hold);
      if (low) sepc_host_model_i.drive_lines(1'b1, 1'b1);
      @(posedge clk);
      reset_n                <= 1'b0;
      interface_enable_strap <= en;
      address_select_strap   <= sel;
      repeat (hold) @(posedge clk);
      #1;
      chk("configured", 8'h00, configured);
      if (hold > 10) chk("deep_sleep", 8'h01, deep_sleep);
      if (hold > 10) chk("oe_deep", 8'h00, {6'h00, scl_oe, sda_oe});
      @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("deep_exit", 8'h00, deep_sleep);
      if (en) wait_sig(0, 1'b1, 200);
      else repeat (60) @(posedge clk);
      if (low) sepc_host_model_i.drive_lines(1'b0, 1'b0);
   endtask

   // One write; bsel sends a binding-select first byte that must be refused.
   task automatic wr(input logic [6:0] a, input int n, input logic ack_exp, input logic bsel);
      logic [7:0] b;
      logic [7:0] r;
      logic       k;
      sepc_host_model_i.start();
      chk("fwt_clear", 8'h00, fwt_expired);
      sepc_host_model_i.byte_io({a, 1'b0}, 1'b1, r, k);
      chk("addr_ack", {7'h00, ack_exp}, {7'h00, ~k});
      for (int i = 0; i < n && ack_exp; i++) begin
         rnd = lfsr_next(rnd);
         b = bsel ? 8'h1f : rnd[7:0];
         if (!bsel && i == 0 && b[3:0] == 4'hf) b[0] = 1'b0;
         if (!bsel) exp_q.push_back(b);
         sepc_host_model_i.byte_io(b, 1'b1, r, k);
         chk("data_ack", {7'h00, ~bsel}, {7'h00, ~k});
      end
      if (bsel) chk("frame_error", 8'h01, frame_error);
      if (ack_exp) chk("fwt_set", 8'h01, fwt_expired);
      sepc_host_model_i.stop();
   endtask

   // Two-byte read, the first byte acknowledged; with v low the slave must fill 0xFF.
   task automatic rd(input logic v);
      logic [7:0] r;
      logic [7:0] e;
      logic       k;
      int         c0;
      rnd = lfsr_next(rnd);
      e   = v ? rnd[7:0] : 8'hff;
      c0  = ready_count;
      @(posedge clk);
      tx_data  <= rnd[7:0];
      tx_valid <= v;
      sepc_host_model_i.start();
      sepc_host_model_i.byte_io({7'h48, 1'b1}, 1'b1, r, k);
      chk("rd_addr_ack", 8'h00, {7'h00, k});
      sepc_host_model_i.byte_io(8'hff, 1'b0, r, k);
      chk("rd_data", e, r);
      sepc_host_model_i.byte_io(8'hff, 1'b1, r, k);
      chk("rd_data2", e, r);
      sepc_host_model_i.stop();
      chk("tx_taken", v ? 8'h02 : 8'h00, 8'(ready_count - c0));
      @(posedge clk);
      tx_valid <= 1'b0;
   endtask

   // --------------------------------------------------------------
   // Processes
   // --------------------------------------------------------------
   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Each received byte is matched to the oldest expected byte.
   always @(posedge clk) begin
      if (rx_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("BAD rx_data expected none seen %h", rx_data);
         end else begin
            chk("rx_data", exp_q.pop_front(), rx_data);
         end
      end
   end

   // Counts outbound bytes actually taken: ready and valid in the same cycle.
   always @(posedge clk) begin
      if (tx_ready === 1'b1 && tx_valid === 1'b1) ready_count++;
   end

   // Cuts a hang short; the run is far below this bound.
   initial begin
      repeat (100000) @(posedge clk);
      fail_count++;
      $display("BAD watchdog expected end seen hang");
      end_sim;
   end

   // Main sequence: addressing, read, sleep, binding refusal, deep sleep, straps.
   initial begin
      reset_n                = 1'b0;
      interface_enable_strap = 1'b0;
      address_select_strap   = 1'b0;
      tx_data                = 8'h00;
      tx_valid               = 1'b0;
      rnd                    = 16'h0a9c;
      fail_count             = 0;
      samples_checked        = 0;
      boot(1'b1, 1'b0, 1'b0, 4);
      wr(7'h48, 3, 1'b1, 1'b0);
      wr(7'h49, 0, 1'b0, 1'b0);
      rd(1'b1);
      rd(1'b0);
      chk("pin_levels", 8'h00, {5'h00, scl_oe, scl_out, sda_out});
      repeat (SLEEP_N - 50) @(posedge clk);
      #1;
      chk("early_sleep", 8'h00, asleep);
      wait_sig(1, 1'b1, 100);
      chk("sda_oe_sleep", 8'h00, sda_oe);
      sepc_host_model_i.wake();
      wait_sig(1, 1'b0, 50);
      chk("configured_wake", 8'h01, configured);
      wr(7'h48, 2, 1'b1, 1'b0);
      wr(7'h48, 1, 1'b1, 1'b1);
      boot(1'b1, 1'b1, 1'b0, 15);
      chk("frame_error_rst", 8'h00, frame_error);
      wr(7'h49, 2, 1'b1, 1'b0);
      wr(7'h48, 0, 1'b0, 1'b0);
      boot(1'b0, 1'b0, 1'b1, 4);
      wr(7'h48, 0, 1'b0, 1'b0);
      repeat (5) @(posedge clk);
      chk("queue_left", 8'h00, 8'(exp_q.size()));
      end_sim;
   end
endmodule
